// ---- logic/rbi_regs.sv ----
// rbi_regs: host register group holding backplane output rates, memory self-test control and identity
// assumes a synchronous host port on clk_sys: one-cycle strobes, read data one cycle later
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// (R1) thirty-two output rate registers each keep a two-bit rate field in bits 1:0, reset to zero.
// (R2) without fast mode a rate field of 0,1,2,3 selects 2, 4, 8 or 16 Mbps for its stream.
// (R3) fast mode ignores the rate fields, runs streams 0 to 15 at 32 Mbps and leaves 16 to 31 unused.
// (R4) software writes zero to the reserved rate bits 15:2 and self-test bits 15:13.
// (R5) software first writes only the enable bit, then enable plus the wanted start bits.
// (R6) self-test bit 12 selects self-test mode when set and normal operation when clear, reset zero.
// (R7) a rising bit 11 starts the backplane data memory test and a rising bit 8 the local one.
// (R8) a rising bit 5 starts the backplane connection memory test and a rising bit 2 the local one.
// (R9) bits 10 and 7 rise when the backplane and local data memory tests complete.
// (R10) bits 4 and 1 rise when the backplane and local connection memory tests complete.
// (R11) bits 9 and 6 give pass (one) or fail (zero) of the data memory tests once done.
// (R12) bits 3 and 0 give pass or fail of the connection memory tests once done.
// (R13) the identity register shows a four-bit revision in bits 7:4 and a three-bit part code in 2:0.
// (R14) identity bits 15:8 and bit 3 read as zero.
// (R15) start edges written with the enable low launch nothing, and done and pass bits ignore writes.
// (R16) writes to the identity register change nothing.
module rbi_regs
  import rbi_pkg::*;
#(
  parameter logic [3:0] SILICON_REVISION_CODE = 4'h5,  // arbitrary value
  parameter logic [2:0] PART_CODE             = 3'h2   // arbitrary value
) (
  input  wire logic                   clk_sys,         // system clock, 100 MHz
  input  wire logic                   resetn,          // async reset, active low
  input  wire logic [ADDR_W-1:0]      host_addr,       // register word address
  input  wire logic                   host_wr,         // write strobe, one cycle
  input  wire logic                   host_rd,         // read strobe, one cycle
  input  wire logic [DATA_W-1:0]      host_wdata,      // write data
  output logic      [DATA_W-1:0]      host_rdata,      // read data, registered
  output logic                        host_rvalid,     // read data valid, pulse
  input  wire logic                   backplane_fast_mode, // 32 Mbps mode from control register
  output logic      [3*NUM_STREAMS-1:0] bp_out_rate_code, // per-stream rate codes, 3 bits each
  output logic                        selftest_enable, // self-test mode
  output logic      [NUM_MEMS-1:0]    memory_selftest_go, // launch pulses: bp dm, lc dm, bp cm, lc cm
  input  wire logic [NUM_MEMS-1:0]    memory_selftest_finish, // engine done pulses
  input  wire logic [NUM_MEMS-1:0]    memory_selftest_ok      // engine pass levels
);
  logic [1:0]        bp_out_rate_field_r [NUM_STREAMS];
  logic [2:0]        rate_code_w [NUM_STREAMS];
  logic [3*NUM_STREAMS-1:0] rate_code_r;
  logic [12:0]       st_ctrl_r;   // bits 12,11,8,5,2 used as written control
  logic [DATA_W-1:0] rdata_r;
  logic              rvalid_r;
  logic [NUM_MEMS-1:0] go_w, done_w, pass_w, start_w;

  wire logic        hit_rate  = (host_addr >= BP_OUT_RATE_BASE) && (host_addr <= BP_OUT_RATE_LAST);
  wire logic [13:0] rate_off  = host_addr - BP_OUT_RATE_BASE;
  wire logic [4:0]  rate_idx  = rate_off[4:0];
  wire logic        hit_st    = (host_addr == SELFTEST_ADDR);
  wire logic        hit_id    = (host_addr == IDENT_ADDR);
  wire logic        st_en     = st_ctrl_r[ST_ENABLE_BIT];
  assign start_w = {st_ctrl_r[BP_DM_START_BIT], st_ctrl_r[LC_DM_START_BIT],
                    st_ctrl_r[BP_CM_START_BIT], st_ctrl_r[LC_CM_START_BIT]};

  genvar g;
  generate
    for (g = 0; g < NUM_STREAMS; g++) begin : g_stream
      always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
          bp_out_rate_field_r[g] <= RATE_RESET;                      // R1
        end else if (host_wr && hit_rate && rate_idx == 5'(g)) begin
          bp_out_rate_field_r[g] <= host_wdata[1:0];                 // R1 R4
        end
      end
      rbi_rate_decode #(.STREAM(g)) u_dec (
        .rate_field (bp_out_rate_field_r[g]),
        .fast_mode  (backplane_fast_mode),
        .rate_code  (rate_code_w[g])
      );
      always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) rate_code_r[3*g +: 3] <= RATE_2M;
        else         rate_code_r[3*g +: 3] <= rate_code_w[g];        // R2 R3
      end
    end
    for (g = 0; g < NUM_MEMS; g++) begin : g_mem
      rbi_mem_test u_test (
        .clk_sys   (clk_sys),
        .resetn    (resetn),
        .enable    (st_en),                                          // R6
        .start_bit (start_w[g]),
        .eng_done  (memory_selftest_finish[g]),
        .eng_pass  (memory_selftest_ok[g]),
        .eng_go    (go_w[g]),
        .done      (done_w[g]),
        .pass      (pass_w[g])
      );
    end
  endgenerate

  // only writable bits are stored; done and pass come from the sequencers
  wire logic [12:0] st_wmask = 13'h1924;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) st_ctrl_r <= SELFTEST_RESET[12:0];                  // R6
    else if (host_wr && hit_st) st_ctrl_r <= host_wdata[12:0] & st_wmask; // R5 R15
  end

  wire logic [15:0] st_read = {3'h0, st_en,
                               start_w[3], done_w[3], pass_w[3],
                               start_w[2], done_w[2], pass_w[2],
                               start_w[1], done_w[1], pass_w[1],
                               start_w[0], done_w[0], pass_w[0]};    // R9 R10 R11 R12
  wire logic [15:0] id_read = {8'h00, SILICON_REVISION_CODE, 1'b0, PART_CODE}; // R13 R14 R16
  wire logic [15:0] rate_read = {14'h0000, bp_out_rate_field_r[rate_idx]};
  wire logic [15:0] rd_mux = hit_rate ? rate_read :
                             hit_st   ? st_read   :
                             hit_id   ? id_read   : 16'h0000;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rdata_r  <= 16'h0000;
      rvalid_r <= 1'b0;
    end else begin
      rvalid_r <= host_rd;
      if (host_rd) rdata_r <= rd_mux;
    end
  end

  logic [NUM_MEMS-1:0] go_r;
  logic                en_r;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      go_r <= 4'h0;
      en_r <= 1'b0;
    end else begin
      go_r <= go_w;                                                  // R7 R8
      en_r <= st_en;
    end
  end

  assign host_rdata         = rdata_r;
  assign host_rvalid        = rvalid_r;
  assign bp_out_rate_code   = rate_code_r;
  assign selftest_enable    = en_r;
  assign memory_selftest_go = go_r;

  // checks
  a_rate_fast_hi: assert property (@(posedge clk_sys) disable iff (!resetn)
    backplane_fast_mode |=> bp_out_rate_code[3*NUM_STREAMS-1 -: 3] == RATE_UNUSED) // R3
    else $error("stream 31 not unused in fast mode");
  a_rate_fast_lo: assert property (@(posedge clk_sys) disable iff (!resetn)
    backplane_fast_mode |=> bp_out_rate_code[2:0] == RATE_32M) // R3
    else $error("stream 0 not 32 Mbps in fast mode");
  a_rate_slow_map: assert property (@(posedge clk_sys) disable iff (!resetn)
    !backplane_fast_mode |=> bp_out_rate_code[2:0] == {1'b0, $past(bp_out_rate_field_r[0])}) // R2
    else $error("stream 0 rate code mismatch");
  a_rate_write_take: assert property (@(posedge clk_sys) disable iff (!resetn)
    host_wr && host_addr == BP_OUT_RATE_BASE |=> bp_out_rate_field_r[0] == $past(host_wdata[1:0])) // R1
    else $error("rate write not stored");
  a_go_needs_en: assert property (@(posedge clk_sys) disable iff (!resetn)
    $rose(memory_selftest_go[3]) |-> $past(st_en, 2)) // R15
    else $error("self-test launched while disabled");
  a_start_edge_go: assert property (@(posedge clk_sys) disable iff (!resetn)
    st_en && $rose(start_w[3]) && $past(st_en) |-> ##2 memory_selftest_go[3]) // R7
    else $error("start edge gave no launch");
  a_conn_edge_go: assert property (@(posedge clk_sys) disable iff (!resetn)
    st_en && $rose(start_w[0]) && $past(st_en) |-> ##2 memory_selftest_go[0]) // R8
    else $error("conn start edge gave no launch");
  a_done_after_eng: assert property (@(posedge clk_sys) disable iff (!resetn)
    $rose(done_w[2]) |-> $past(memory_selftest_finish[2])) // R9
    else $error("done rose without engine finish");
  a_pass_capture: assert property (@(posedge clk_sys) disable iff (!resetn)
    $rose(done_w[1]) |-> pass_w[1] == $past(memory_selftest_ok[1])) // R12
    else $error("pass not captured from engine");
  a_cdone_src: assert property (@(posedge clk_sys) disable iff (!resetn)
    $rose(done_w[0]) |-> $past(memory_selftest_finish[0])) // R10
    else $error("conn done rose without finish");
  a_id_read_val: assert property (@(posedge clk_sys) disable iff (!resetn)
    host_rd && hit_id |=> host_rvalid && host_rdata == {8'h00, SILICON_REVISION_CODE, 1'b0, PART_CODE}) // R13
    else $error("identity read wrong");
  a_en_mode_out: assert property (@(posedge clk_sys) disable iff (!resetn)
    host_wr && hit_st |=> ##1 selftest_enable == $past(host_wdata[ST_ENABLE_BIT], 2)) // R6
    else $error("enable output does not follow write");
  c_fast_mode: cover property (@(posedge clk_sys) disable iff (!resetn) $rose(backplane_fast_mode));
  c_test_launch: cover property (@(posedge clk_sys) disable iff (!resetn) $rose(memory_selftest_go[3]));
  c_test_done: cover property (@(posedge clk_sys) disable iff (!resetn) $rose(done_w[3]) && pass_w[3]);
endmodule // rbi_regs
`default_nettype wire

// ---- logic/rbi_pkg.sv ----
// rbi_pkg: register map, field positions and codes for the rate, self-test and identity register group
// assumes a 14-bit word address and 16-bit data on the host register port
package rbi_pkg;
  localparam int          ADDR_W          = 14;
  localparam int          DATA_W          = 16;
  localparam int          NUM_STREAMS     = 32;
  localparam logic [13:0] BP_OUT_RATE_BASE = 14'h012D;
  localparam logic [13:0] BP_OUT_RATE_LAST = 14'h014C;
  localparam logic [13:0] SELFTEST_ADDR   = 14'h014D;
  localparam logic [13:0] IDENT_ADDR      = 14'h3FFF;
  localparam logic [1:0]  RATE_RESET      = 2'h0;
  localparam int          ST_ENABLE_BIT   = 12;
  localparam int          BP_DM_START_BIT = 11;
  localparam int          BP_DM_DONE_BIT  = 10;
  localparam int          BP_DM_PASS_BIT  = 9;
  localparam int          LC_DM_START_BIT = 8;
  localparam int          LC_DM_DONE_BIT  = 7;
  localparam int          LC_DM_PASS_BIT  = 6;
  localparam int          BP_CM_START_BIT = 5;
  localparam int          BP_CM_DONE_BIT  = 4;
  localparam int          BP_CM_PASS_BIT  = 3;
  localparam int          LC_CM_START_BIT = 2;
  localparam int          LC_CM_DONE_BIT  = 1;
  localparam int          LC_CM_PASS_BIT  = 0;
  localparam int          NUM_MEMS        = 4;
  localparam logic [15:0] SELFTEST_RESET  = 16'h0000;
  // rate codes on the per-stream rate outputs
  localparam logic [2:0]  RATE_2M         = 3'h0;
  localparam logic [2:0]  RATE_4M         = 3'h1;
  localparam logic [2:0]  RATE_8M         = 3'h2;
  localparam logic [2:0]  RATE_16M        = 3'h3;
  localparam logic [2:0]  RATE_32M        = 3'h4;
  localparam logic [2:0]  RATE_UNUSED     = 3'h7;
  localparam int          FAST_STREAMS    = 16;
  typedef enum logic [2:0] {
    RBI_ST_IDLE = 3'b001,
    RBI_ST_RUN  = 3'b010,
    RBI_ST_DONE = 3'b100
  } rbi_test_e;
endpackage

// ---- logic/rbi_rate_decode.sv ----
// rbi_rate_decode: turns one stream's rate field and the backplane fast mode into a rate code
// assumes inputs come from registers in the same clock domain
`timescale 1ns/100ps
`default_nettype none
module rbi_rate_decode
  import rbi_pkg::*;
#(
  parameter int STREAM = 0
) (
  input  wire logic [1:0] rate_field,  // stored rate field
  input  wire logic       fast_mode,   // backplane 32 Mbps mode
  output logic      [2:0] rate_code    // decoded rate
);
  wire logic [2:0] slow_code = {1'b0, rate_field};                 // R2
  wire logic [2:0] fast_code = (STREAM < FAST_STREAMS) ? RATE_32M : RATE_UNUSED; // R3
  assign rate_code = fast_mode ? fast_code : slow_code;            // R3
endmodule // rbi_rate_decode
`default_nettype wire

// ---- logic/rbi_mem_test.sv ----
// rbi_mem_test: sequencer for one memory self-test: start edge, run, done and pass capture
// assumes the memory test engine outside answers with a done pulse and a pass level
`timescale 1ns/100ps
`default_nettype none
module rbi_mem_test
  import rbi_pkg::*;
(
  input  wire logic clk_sys,     // system clock
  input  wire logic resetn,      // async reset, active low
  input  wire logic enable,      // self-test mode
  input  wire logic start_bit,   // stored start bit
  input  wire logic eng_done,    // engine finished, pulse
  input  wire logic eng_pass,    // engine result
  output logic      eng_go,      // launch pulse to engine
  output logic      done,        // completion flag
  output logic      pass         // result flag
);
  rbi_test_e  state_r, state_nxt;
  logic       start_prev_r;
  logic       go_r, done_r, pass_r;
  wire logic  rise = start_bit & ~start_prev_r & enable;  // R15
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      RBI_ST_IDLE: if (rise) state_nxt = RBI_ST_RUN;
      RBI_ST_RUN:  if (!enable) state_nxt = RBI_ST_IDLE;
                   else if (eng_done) state_nxt = RBI_ST_DONE;
      RBI_ST_DONE: if (rise) state_nxt = RBI_ST_RUN;
                   else if (!enable) state_nxt = RBI_ST_IDLE;
      default:     state_nxt = RBI_ST_IDLE;
    endcase
  end
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state_r      <= RBI_ST_IDLE;
      start_prev_r <= 1'b0;
      go_r         <= 1'b0;
      done_r       <= 1'b0;
      pass_r       <= 1'b0;
    end else begin
      state_r      <= state_nxt;
      start_prev_r <= start_bit;
      go_r         <= rise;                                           // R7 R8
      done_r       <= (state_nxt == RBI_ST_DONE);                     // R9 R10
      pass_r       <= (state_r == RBI_ST_RUN && eng_done) ? eng_pass  // R11 R12
                      : (rise ? 1'b0 : pass_r);
    end
  end
  assign eng_go = go_r;
  assign done   = done_r;
  assign pass   = pass_r;
endmodule // rbi_mem_test
`default_nettype wire

// ---- verification/rbi_host_bfm.sv ----
// rbi_host_bfm: host processor model for the register port of the rate, self-test and identity group
// assumes one-cycle strobes taken on the rising edge and read data valid one cycle after the read strobe
`timescale 1ns/100ps
`default_nettype none
module rbi_host_bfm
  import rbi_pkg::*;
(
  input  wire logic              clk_sys,     // system clock
  input  wire logic [DATA_W-1:0] host_rdata,  // read data
  input  wire logic              host_rvalid, // read data valid
  output logic      [ADDR_W-1:0] host_addr,   // word address
  output logic                   host_wr,     // write strobe
  output logic                   host_rd,     // read strobe
  output logic      [DATA_W-1:0] host_wdata   // write data
);
  initial begin
    host_addr  = '0;
    host_wr    = 1'b0;
    host_rd    = 1'b0;
    host_wdata = '0;
  end

  // released lines carry the inverse of the last value so stale data never looks valid
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk_sys);
    host_addr  <= a;
    host_wdata <= d;
    host_wr    <= 1'b1;
    @(posedge clk_sys);
    host_wr    <= 1'b0;
    host_addr  <= ~a;
    host_wdata <= ~d;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d, output logic v);
    @(posedge clk_sys);
    host_addr <= a;
    host_rd   <= 1'b1;
    @(posedge clk_sys);
    host_rd   <= 1'b0;
    host_addr <= ~a;
    // answer stands for the whole next cycle, so take it at the edge that closes it
    @(posedge clk_sys);
    d = host_rdata;
    v = host_rvalid;
  endtask
endmodule // rbi_host_bfm
`default_nettype wire

// ---- verification/tb_rbi_regs.sv ----
// tb_rbi_regs: self-checking bench for the rate, self-test and identity register group
// assumes rbi_pkg and the host model; the bench plays the memory test engines itself
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin err_count++; \
  $display("unexpected %s expected %h seen %h", nm, e, g); end end
module tb_rbi_regs;
  import rbi_pkg::*;
  localparam logic [3:0] REV  = 4'hA;  // arbitrary value
  localparam logic [2:0] PART = 3'h6;  // arbitrary value
  logic                     clk_sys = 1'b0;
  logic                     resetn;
  logic [ADDR_W-1:0]        host_addr;
  logic                     host_wr;
  logic                     host_rd;
  logic [DATA_W-1:0]        host_wdata;
  logic [DATA_W-1:0]        host_rdata;
  logic                     host_rvalid;
  logic                     fast_mode;
  logic [3*NUM_STREAMS-1:0] rate_code;
  logic                     st_enable;
  logic [NUM_MEMS-1:0]      go;
  logic [NUM_MEMS-1:0]      finish;
  logic [NUM_MEMS-1:0]      ok;
  int                       err_count = 0;
  int                       check_count = 0;
  logic [2:0]               rate_exp [4] = '{RATE_2M, RATE_4M, RATE_8M, RATE_16M};

  always #5 clk_sys = ~clk_sys;

  rbi_regs #(.SILICON_REVISION_CODE(REV), .PART_CODE(PART)) DUT (
    .clk_sys(clk_sys), .resetn(resetn), .host_addr(host_addr), .host_wr(host_wr), .host_rd(host_rd),
    .host_wdata(host_wdata), .host_rdata(host_rdata), .host_rvalid(host_rvalid),
    .backplane_fast_mode(fast_mode), .bp_out_rate_code(rate_code), .selftest_enable(st_enable),
    .memory_selftest_go(go), .memory_selftest_finish(finish), .memory_selftest_ok(ok));

  rbi_host_bfm host (
    .clk_sys(clk_sys), .host_rdata(host_rdata), .host_rvalid(host_rvalid), .host_addr(host_addr),
    .host_wr(host_wr), .host_rd(host_rd), .host_wdata(host_wdata));

  task automatic rchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    logic [DATA_W-1:0] d;
    logic              v;
    host.rd(a, d, v);
    `CHK("host_rvalid", 1'b1, v)
    `CHK("host_rdata", e, d)
  endtask

  task automatic chk_rates(input logic fast);
    logic [2:0] e;
    for (int n = 0; n < NUM_STREAMS; n++) begin
      e = fast ? ((n < FAST_STREAMS) ? RATE_32M : RATE_UNUSED) : rate_exp[n % 4];
      `CHK("bp_out_rate_code", e, rate_code[3*n +: 3])
    end
  endtask

  task automatic t_reset;
    for (int n = 0; n < NUM_STREAMS; n++) rchk(BP_OUT_RATE_BASE + 14'(n), 16'h0000);
    `CHK("rate codes at reset", 96'h0, rate_code)
    rchk(SELFTEST_ADDR, SELFTEST_RESET);
    `CHK("selftest_enable", 1'b0, st_enable)
    rchk(IDENT_ADDR, {8'h00, REV, 1'b0, PART});
  endtask

  task automatic t_rates;
    for (int n = 0; n < NUM_STREAMS; n++) host.wr(BP_OUT_RATE_BASE + 14'(n), {14'h0, 2'(n)});
    for (int n = 0; n < NUM_STREAMS; n++) rchk(BP_OUT_RATE_BASE + 14'(n), {14'h0, 2'(n)});
    chk_rates(1'b0);
    @(posedge clk_sys);
    fast_mode <= 1'b1;
    repeat (2) @(posedge clk_sys);
    #1;
    chk_rates(1'b1);
    @(posedge clk_sys);
    fast_mode <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    chk_rates(1'b0);
  endtask

  task automatic t_ident;
    host.wr(IDENT_ADDR, 16'hFFFF);
    rchk(IDENT_ADDR, {8'h00, REV, 1'b0, PART});
    host.wr(14'h0000, 16'h0003);
    rchk(14'h0000, 16'h0000);
  endtask

  task automatic watch_go(output logic [NUM_MEMS-1:0] g, output int at);
    g  = '0;
    at = -1;
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_sys);
      #1;
      if (go !== 4'h0 && at < 0) begin
        g  = go;
        at = i;
      end
    end
  endtask

  task automatic t_selftest;
    logic [NUM_MEMS-1:0] g;
    int                  at;
    host.wr(SELFTEST_ADDR, 16'h0800);
    watch_go(g, at);
    `CHK("go with enable low", 4'h0, g)
    host.wr(SELFTEST_ADDR, 16'h0000);
    host.wr(SELFTEST_ADDR, 16'h1000);
    host.wr(SELFTEST_ADDR, 16'h1924);
    watch_go(g, at);
    `CHK("launch pulses", 4'hF, g)
    `CHK("selftest_enable", 1'b1, st_enable)
    rchk(SELFTEST_ADDR, 16'h1924);
    @(posedge clk_sys);
    finish <= 4'hF;
    ok     <= 4'hA;
    @(posedge clk_sys);
    finish <= 4'h0;
    ok     <= 4'h5;
    rchk(SELFTEST_ADDR, 16'h1FBE);
    host.wr(SELFTEST_ADDR, 16'h1FFF);
    rchk(SELFTEST_ADDR, 16'h1FBE);
    host.wr(SELFTEST_ADDR, 16'h0000);
    // done drops with the enable, pass keeps the last result until a new launch
    rchk(SELFTEST_ADDR, 16'h0208);
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    resetn    = 1'b0;
    fast_mode = 1'b0;
    finish    = 4'h0;
    ok        = 4'h0;
    repeat (20) @(posedge clk_sys);
    resetn <= 1'b1;
    t_reset;
    t_rates;
    t_ident;
    t_selftest;
    summarize;
  end

  // the whole run takes a few hundred cycles, so this only fires on a hang
  initial begin
    #200000;
    err_count++;
    summarize;
  end
endmodule // tb_rbi_regs
`default_nettype wire
